// [rtl/conv_seq.sv]
// per-converter power state machine with turn-on and turn-off limits
`default_nettype none
module conv_seq (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// sequencing
	input wire logic tick_in,
	input wire logic up_in,
	input wire logic down_in,
	input wire logic pgood_in,
	input wire seq_pkg::conv_cfg_s cfg_in,
	// state
	output var seq_pkg::conv_stat_s stat_out
);
	import seq_pkg::*;

	conv_reg_s q, d;

	// ==========================================================================
	// state machine
	always_comb begin
		d = q;
		if (tick_in) begin
			d.cnt = q.cnt + 16'h0001;
		end
		unique case (q.st)
			CS_OFF: if (up_in) begin
				d.st = CS_RAMP;
				d.cnt = '0;
				d.fault = 1'b0;
				d.warn = 1'b0;
			end
			CS_RAMP: if (down_in) begin
				d.st = CS_DOWN;
				d.cnt = '0;
			end else if (pgood_in) begin
				d.st = CS_ON;
			end else if (tick_in && q.cnt == cfg_in.on_max) begin
				d.st = CS_DOWN;
				d.fault = 1'b1;
				d.cnt = '0;
			end
			CS_ON: if (down_in || !pgood_in) begin
				d.st = CS_DOWN;
				d.fault = q.fault | ~pgood_in;
				d.cnt = '0;
			end
			CS_DOWN: if (!pgood_in) begin
				d.st = CS_OFF;
			end else if (tick_in && q.cnt == cfg_in.off_max) begin
				// a stuck converter is reported, not waited on forever
				d.st = CS_OFF;
				d.warn = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			q <= '0;
			q.st <= CS_OFF;
		end else begin
			q <= d;
		end
	end

	assign stat_out = '{en: q.st == CS_RAMP || q.st == CS_ON, is_on: q.st == CS_ON,
		is_off: q.st == CS_OFF, fault: q.fault, warn: q.warn};

	// ==========================================================================
	// checks
	sequence s_on_timeout;
		q.st == CS_RAMP && !down_in && !pgood_in && tick_in && q.cnt == cfg_in.on_max;
	endsequence
	sequence s_off_timeout;
		q.st == CS_DOWN && pgood_in && tick_in && q.cnt == cfg_in.off_max;
	endsequence
	AST_ON_TIMEOUT_FAULT: assert property (@(posedge clk_in) disable iff (rst_in)
		s_on_timeout |=> q.st == CS_DOWN && q.fault && !stat_out.en)
		else $error("turn-on timeout did not fault and drop enable");
	AST_OFF_TIMEOUT_WARN: assert property (@(posedge clk_in) disable iff (rst_in)
		s_off_timeout |=> q.st == CS_OFF && q.warn)
		else $error("shutdown overtime did not raise warning");
endmodule
`default_nettype wire

// [rtl/power_converter_sequencer.sv]
// top of the power converter sequencer: registers, global control, outputs
//
// The implementer's own choices: the register addresses and strobed register access.
`default_nettype none
module power_converter_sequencer #(
	parameter int N_CONV = seq_pkg::DEF_CONV,
	parameter int N_CTL = seq_pkg::DEF_CTL,
	parameter int N_STS = seq_pkg::DEF_STS,
	parameter int TICK_CYCLES = seq_pkg::TICK_CYCLES,
	parameter bit WARN_EN = 1'b1,
	parameter int CTL_W = (N_CTL > 0) ? N_CTL : 1,
	parameter int STS_W = (N_STS > 0) ? N_STS : 1
) (
	// clock and reset
	input wire logic REF_CLK_IN,
	input wire logic RESET_IN,
	// register port
	input wire seq_pkg::bus_req_s BUS_REQ_IN,
	output logic [31:0] BUS_RDATA_OUT,
	// sequencing control
	input wire logic ENABLE_IN,
	input wire logic [CTL_W-1:0] CTL_IN,
	// converters
	input wire logic [N_CONV-1:0] PGOOD_IN,
	output logic [N_CONV-1:0] CONV_EN_OUT,
	// system status
	output logic SYS_STABLE_OUT,
	output logic SYS_UP_OUT,
	output logic SYS_DOWN_OUT,
	output logic WARN_OUT,
	output logic FAULT_OUT,
	output logic [STS_W-1:0] STS_OUT
);
	import seq_pkg::*;

	typedef struct packed {
		logic [31:0] rdata;
		logic [MAX_CONV-1:0] en;
		logic stable;
		logic up;
		logic down;
		logic warn;
		logic fault;
		logic [MAX_STS-1:0] sts;
		logic en_pin;
		logic up_req;
		logic down_req;
		logic [MAX_CONV-1:0] dn_scope;
		logic [CNT_W-1:0] tick_cnt;
		logic [4:0] slow_cnt;
		logic [CNT_W-1:0] stable_cnt;
		logic en_up;
		logic en_dn;
		logic [MAX_CTL-1:0] gate_mask;
		logic [MAX_CTL-1:0] force_mask;
		logic [MAX_CTL-1:0] ctl_pol;
		logic [MAX_STS-1:0] sts_pol;
		logic [CNT_W-1:0] on_max;
		logic [CNT_W-1:0] off_max;
		logic [CNT_W-1:0] stable_time;
		logic [MAX_CONV-1:0] down_sel;
		logic [MAX_STS-1:0][MAX_CONV-1:0] sts_mask;
		logic [MAX_STS-1:0][MAX_CONV-1:0] sts_pgpol;
	} top_reg_s;

	top_reg_s q, d;
	conv_stat_s stat [N_CONV];
	conv_cfg_s cfg;
	logic [N_CONV-1:0] c_up;
	logic [N_CONV-1:0] c_down;
	logic [N_CONV-1:0] c_on;
	logic [N_CONV-1:0] c_off;
	logic [N_CONV-1:0] c_en;
	logic [N_CONV-1:0] c_fault;
	logic [N_CONV-1:0] c_warn;
	logic [MAX_CONV-1:0] pg_all;
	logic [MAX_CONV-1:0] conv_exist;
	logic [MAX_CTL-1:0] ctl_act;
	logic tick;
	logic slow_tick;
	logic gate_ok;
	logic ctl_force;
	logic cmd_on;
	logic cmd_off;
	logic trig_up;
	logic trig_dn;
	logic new_fault;
	logic all_on;
	logic all_off;
	logic any_fault;
	logic any_warn;
	logic sts_hit;
	logic [2:0] sts_idx;
	logic sts0_exp;

	// ==========================================================================
	// time base: 0.25 ms tick and 8 ms slow tick, both one-cycle enables
	assign tick = q.tick_cnt == CNT_W'(TICK_CYCLES - 1);
	assign slow_tick = tick && q.slow_cnt == 5'(SLOW_DIV - 1);

	// ==========================================================================
	// inputs and decoded conditions
	assign pg_all = MAX_CONV'(PGOOD_IN);
	assign conv_exist = MAX_CONV'({N_CONV{1'b1}});
	assign cfg = '{on_max: q.on_max, off_max: q.off_max};

	always_comb begin
		ctl_act = '1;
		for (int i = 0; i < N_CTL; i++) begin
			ctl_act[i] = CTL_IN[i] ^ q.ctl_pol[i];
		end
	end

	assign gate_ok = &(ctl_act | ~q.gate_mask);
	assign ctl_force = |(~ctl_act & q.force_mask);
	assign cmd_on = BUS_REQ_IN.wr && BUS_REQ_IN.addr == REG_CTRL
		&& BUS_REQ_IN.wdata[CTRL_CMD_ON_BIT];
	assign cmd_off = BUS_REQ_IN.wr && BUS_REQ_IN.addr == REG_CTRL
		&& BUS_REQ_IN.wdata[CTRL_CMD_OFF_BIT];
	assign all_on = &c_on;
	assign all_off = &c_off;
	assign any_fault = |c_fault;
	assign any_warn = |c_warn;
	assign new_fault = any_fault && !q.fault;
	assign trig_up = (q.en_up && ENABLE_IN && !q.en_pin) || cmd_on;
	assign trig_dn = (q.en_dn && !ENABLE_IN && q.en_pin) || cmd_off
		|| ctl_force || new_fault;
	assign sts_hit = BUS_REQ_IN.addr >= REG_STS_BASE
		&& BUS_REQ_IN.addr < REG_STS_BASE + 8'(8 * MAX_STS);
	assign sts_idx = 3'((BUS_REQ_IN.addr - REG_STS_BASE) >> 3);

	// ==========================================================================
	// converters: power up in index order, power down in reverse order
	for (genvar g = 0; g < N_CONV; g++) begin : g_conv
		logic prev_ok;
		logic next_busy;
		if (g == 0) begin : g_first
			assign prev_ok = 1'b1;
		end else begin : g_up_chain
			assign prev_ok = stat[g - 1].is_on;
		end
		if (g == N_CONV - 1) begin : g_last
			assign next_busy = 1'b0;
		end else begin : g_dn_chain
			assign next_busy = stat[g + 1].en & q.dn_scope[g + 1];
		end
		assign c_up[g] = q.up_req & gate_ok & prev_ok;
		assign c_down[g] = q.down_req & q.dn_scope[g] & ~next_busy;
		conv_seq u_seq (
			.clk_in(REF_CLK_IN),
			.rst_in(RESET_IN),
			.tick_in(tick),
			.up_in(c_up[g]),
			.down_in(c_down[g]),
			.pgood_in(PGOOD_IN[g]),
			.cfg_in(cfg),
			.stat_out(stat[g])
		);
		assign c_on[g] = stat[g].is_on;
		assign c_off[g] = stat[g].is_off;
		assign c_en[g] = stat[g].en;
		assign c_fault[g] = stat[g].fault;
		assign c_warn[g] = stat[g].warn;
	end

	// ==========================================================================
	// next state
	always_comb begin
		d = q;
		d.rdata = '0;
		d.en_pin = ENABLE_IN;
		d.tick_cnt = tick ? '0 : q.tick_cnt + 16'h0001;
		if (tick) begin
			d.slow_cnt = slow_tick ? '0 : q.slow_cnt + 5'h01;
		end
		// power-down wins over power-up when both arrive together
		if (trig_up) begin
			d.up_req = 1'b1;
			d.down_req = 1'b0;
		end
		if (trig_dn) begin
			d.up_req = 1'b0;
			d.down_req = 1'b1;
			// a control input alone only takes down the selected group
			d.dn_scope = (ctl_force && !new_fault && !cmd_off && !(q.en_dn && !ENABLE_IN
				&& q.en_pin)) ? q.down_sel : '1;
		end
		// stability timer in 8 ms steps, restarted whenever any converter leaves on
		if (!all_on) begin
			d.stable_cnt = '0;
		end else if (slow_tick && q.stable_cnt != '1) begin
			d.stable_cnt = q.stable_cnt + 16'h0001;
		end
		d.stable = all_on && q.stable_cnt >= q.stable_time;
		d.up = all_on;
		d.down = all_off;
		d.warn = WARN_EN && any_warn;
		d.fault = any_fault;
		d.en = MAX_CONV'(c_en);
		d.sts = '0;
		for (int i = 0; i < N_STS; i++) begin
			d.sts[i] = sts_eq(pg_all, q.sts_mask[i] & conv_exist, q.sts_pgpol[i])
				^ q.sts_pol[i];
		end
		// register writes
		if (BUS_REQ_IN.wr) begin
			case (BUS_REQ_IN.addr)
				REG_CTRL: begin
					d.en_up = BUS_REQ_IN.wdata[CTRL_EN_UP_BIT];
					d.en_dn = BUS_REQ_IN.wdata[CTRL_EN_DN_BIT];
					d.gate_mask = BUS_REQ_IN.wdata[CTRL_GATE_LSB +: MAX_CTL];
					d.force_mask = BUS_REQ_IN.wdata[CTRL_FORCE_LSB +: MAX_CTL];
				end
				REG_POL: begin
					d.ctl_pol = BUS_REQ_IN.wdata[POL_CTL_LSB +: MAX_CTL];
					d.sts_pol = BUS_REQ_IN.wdata[POL_STS_LSB +: MAX_STS];
				end
				REG_ON_MAX: d.on_max = BUS_REQ_IN.wdata[CNT_W-1:0];
				REG_OFF_MAX: d.off_max = BUS_REQ_IN.wdata[CNT_W-1:0];
				REG_STABLE: d.stable_time = BUS_REQ_IN.wdata[CNT_W-1:0];
				REG_DOWN_SEL: d.down_sel = BUS_REQ_IN.wdata;
				default: if (sts_hit) begin
					if (BUS_REQ_IN.addr[2]) begin
						d.sts_pgpol[sts_idx] = BUS_REQ_IN.wdata;
					end else begin
						d.sts_mask[sts_idx] = BUS_REQ_IN.wdata;
					end
				end
			endcase
		end
		// register reads, data valid in the next cycle only
		if (BUS_REQ_IN.rd) begin
			case (BUS_REQ_IN.addr)
				REG_CTRL: begin
					d.rdata[CTRL_EN_UP_BIT] = q.en_up;
					d.rdata[CTRL_EN_DN_BIT] = q.en_dn;
					d.rdata[CTRL_GATE_LSB +: MAX_CTL] = q.gate_mask;
					d.rdata[CTRL_FORCE_LSB +: MAX_CTL] = q.force_mask;
				end
				REG_POL: begin
					d.rdata[POL_CTL_LSB +: MAX_CTL] = q.ctl_pol;
					d.rdata[POL_STS_LSB +: MAX_STS] = q.sts_pol;
				end
				REG_ON_MAX: d.rdata[CNT_W-1:0] = q.on_max;
				REG_OFF_MAX: d.rdata[CNT_W-1:0] = q.off_max;
				REG_STABLE: d.rdata[CNT_W-1:0] = q.stable_time;
				REG_DOWN_SEL: d.rdata = q.down_sel;
				REG_STATUS: begin
					d.rdata[STAT_UP_BIT] = q.up;
					d.rdata[STAT_DOWN_BIT] = q.down;
					d.rdata[STAT_STABLE_BIT] = q.stable;
					d.rdata[STAT_WARN_BIT] = q.warn;
					d.rdata[STAT_FAULT_BIT] = q.fault;
					d.rdata[STAT_UPREQ_BIT] = q.up_req;
					d.rdata[STAT_DNREQ_BIT] = q.down_req;
				end
				REG_PGOOD: d.rdata = pg_all;
				REG_FAULTS: d.rdata = MAX_CONV'(c_fault);
				REG_WARNS: d.rdata = MAX_CONV'(c_warn);
				REG_ENABLES: d.rdata = q.en;
				default: if (sts_hit) begin
					d.rdata = BUS_REQ_IN.addr[2] ? q.sts_pgpol[sts_idx] : q.sts_mask[sts_idx];
				end
			endcase
		end
	end

	// ==========================================================================
	// state register
	always_ff @(posedge REF_CLK_IN) begin
		if (RESET_IN) begin
			q <= '0;
			q.en_up <= RST_EN_UP;
			q.en_dn <= RST_EN_DN;
			q.on_max <= RST_ON_MAX;
			q.off_max <= RST_OFF_MAX;
			q.stable_time <= RST_STABLE;
			q.down_sel <= RST_DOWN_SEL;
			q.dn_scope <= RST_DOWN_SEL;
		end else begin
			q <= d;
		end
	end

	// ==========================================================================
	// outputs, all straight from flip-flops
	assign BUS_RDATA_OUT = q.rdata;
	assign CONV_EN_OUT = q.en[N_CONV-1:0];
	assign SYS_STABLE_OUT = q.stable;
	assign SYS_UP_OUT = q.up;
	assign SYS_DOWN_OUT = q.down;
	assign WARN_OUT = q.warn;
	assign FAULT_OUT = q.fault;
	assign STS_OUT = q.sts[STS_W-1:0];

	// ==========================================================================
	// checks
	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (RESET_IN);

	// independent form of the status equation: no selected converter disagrees
	assign sts0_exp = (N_STS == 0) ? 1'b0
		: (((q.sts_mask[0] & conv_exist & (pg_all ^ q.sts_pgpol[0])) == '0) ^ q.sts_pol[0]);

	sequence s_enable_rise;
		q.en_up && ENABLE_IN && !q.en_pin;
	endsequence
	sequence s_no_down_cause;
		!trig_dn;
	endsequence

	AST_UP_FOLLOWS_ALL_ON: assert property (!RESET_IN |=> SYS_UP_OUT == $past(all_on))
		else $error("system up does not follow all converters on");
	AST_DOWN_FOLLOWS_ALL_OFF: assert property (!RESET_IN |=>
		SYS_DOWN_OUT == $past(all_off))
		else $error("system down does not follow all converters off");
	AST_STABLE_AFTER_TIME: assert property ($rose(SYS_STABLE_OUT) |->
		$past(all_on) && $past(q.stable_cnt) >= $past(q.stable_time))
		else $error("system stable raised before the stable time");
	AST_FAULT_OUT: assert property (any_fault |=> FAULT_OUT)
		else $error("fault output missed a converter fault");
	AST_WARN_OUT: assert property (any_warn |=> WARN_OUT == WARN_EN)
		else $error("warning output wrong for converter warning");
	AST_ENABLE_START: assert property (s_enable_rise and s_no_down_cause |=> q.up_req)
		else $error("enable rise did not request power up");
	AST_GATE_HOLDS: assert property (!gate_ok && c_off[0] |=> c_off[0])
		else $error("closed gate let a converter power up");
	AST_EN_MIRROR: assert property (!RESET_IN |=> CONV_EN_OUT[0] == $past(c_en[0]))
		else $error("enable output does not follow converter state");
	AST_EN_MIRROR_LAST: assert property (!RESET_IN |=>
		CONV_EN_OUT[N_CONV-1] == $past(c_en[N_CONV-1]))
		else $error("last enable output does not follow converter state");
	AST_STS_EQUATION: assert property (!RESET_IN |=> STS_OUT[0] == $past(sts0_exp))
		else $error("status output disagrees with its equation");

	// cross-output, force input and register port checks
	AST_UP_DOWN_APART: assert property (!(SYS_UP_OUT && SYS_DOWN_OUT))
		else $error("system up and system down both high");
	AST_STABLE_NEEDS_UP: assert property (SYS_STABLE_OUT |-> SYS_UP_OUT)
		else $error("system stable without system up");
	AST_FORCE_DOWN: assert property (ctl_force |=> q.down_req && !q.up_req)
		else $error("deasserted force input did not request power down");
	AST_RDATA_IDLE: assert property (!BUS_REQ_IN.rd |=> BUS_RDATA_OUT == '0)
		else $error("read data present without a read");
endmodule
`default_nettype wire

// [rtl/seq_pkg.sv]
// constants, types and shared functions of the power converter sequencer
// ==========================================================================
`default_nettype none
package seq_pkg;
	// ==========================================================================
	// sizes and timing
	localparam int MAX_CONV = 32;
	localparam int MAX_CTL = 6;
	localparam int MAX_STS = 6;
	localparam int DEF_CONV = 8;
	localparam int DEF_CTL = 1;
	localparam int DEF_STS = 1;
	localparam int CLK_HZ = 40_000_000;
	localparam int TICK_US = 250;
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	localparam int SLOW_DIV = 32;
	localparam int CNT_W = 16;
	// ==========================================================================
	// register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_POL = 8'h04;
	localparam logic [7:0] REG_ON_MAX = 8'h08;
	localparam logic [7:0] REG_OFF_MAX = 8'h0c;
	localparam logic [7:0] REG_STABLE = 8'h10;
	localparam logic [7:0] REG_DOWN_SEL = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;
	localparam logic [7:0] REG_PGOOD = 8'h1c;
	localparam logic [7:0] REG_FAULTS = 8'h20;
	localparam logic [7:0] REG_WARNS = 8'h24;
	localparam logic [7:0] REG_ENABLES = 8'h28;
	localparam logic [7:0] REG_STS_BASE = 8'h40;
	// ==========================================================================
	// field positions
	localparam int CTRL_EN_UP_BIT = 0;
	localparam int CTRL_EN_DN_BIT = 1;
	localparam int CTRL_CMD_ON_BIT = 2;
	localparam int CTRL_CMD_OFF_BIT = 3;
	localparam int CTRL_GATE_LSB = 8;
	localparam int CTRL_FORCE_LSB = 16;
	localparam int POL_CTL_LSB = 0;
	localparam int POL_STS_LSB = 8;
	localparam int STAT_UP_BIT = 0;
	localparam int STAT_DOWN_BIT = 1;
	localparam int STAT_STABLE_BIT = 2;
	localparam int STAT_WARN_BIT = 3;
	localparam int STAT_FAULT_BIT = 4;
	localparam int STAT_UPREQ_BIT = 5;
	localparam int STAT_DNREQ_BIT = 6;
	// ==========================================================================
	// reset values
	localparam logic RST_EN_UP = 1'b1;
	localparam logic RST_EN_DN = 1'b1;
	localparam logic [CNT_W-1:0] RST_ON_MAX = 16'h0064;
	localparam logic [CNT_W-1:0] RST_OFF_MAX = 16'h0064;
	localparam logic [CNT_W-1:0] RST_STABLE = 16'h00fa;
	localparam logic [MAX_CONV-1:0] RST_DOWN_SEL = 32'hffffffff;
	// ==========================================================================
	// types
	typedef enum logic [3:0] {
		CS_OFF = 4'b0001,
		CS_RAMP = 4'b0010,
		CS_ON = 4'b0100,
		CS_DOWN = 4'b1000
	} conv_state_e;
	typedef struct packed {
		logic [CNT_W-1:0] on_max;
		logic [CNT_W-1:0] off_max;
	} conv_cfg_s;
	typedef struct packed {
		logic en;
		logic is_on;
		logic is_off;
		logic fault;
		logic warn;
	} conv_stat_s;
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_s;
	typedef struct packed {
		conv_state_e st;
		logic [CNT_W-1:0] cnt;
		logic fault;
		logic warn;
	} conv_reg_s;
	// ==========================================================================
	// status equation: AND of selected power-goods, each true or inverted
	function automatic logic sts_eq(input logic [MAX_CONV-1:0] pg,
		input logic [MAX_CONV-1:0] mask, input logic [MAX_CONV-1:0] pol);
		sts_eq = &(~mask | ~(pg ^ pol));
	endfunction
endpackage
`default_nettype wire

// [verification/conv_model.sv]
// behavioural model of the external power converters seen by the sequencer
`default_nettype none
module conv_model #(
	parameter int N = 2,
	parameter int FAST = 2,
	parameter int SLOW = 9
) (
	// clock
	input wire logic clk_in,
	// enables from the sequencer
	input wire logic [N-1:0] en_in,
	// misbehaviour commanded by the bench
	input wire logic [N-1:0] slow_in,
	input wire logic [N-1:0] dead_in,
	input wire logic [N-1:0] stuck_in,
	// composite power-good back to the sequencer
	output logic [N-1:0] pgood_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================================
	// output settling
	int cnt [N];

	initial begin
		pgood_out = '0;
		foreach (cnt[i]) cnt[i] = 0;
	end

	// one composite power-good per converter; sources already combined here
	// dead never comes up, stuck never goes down, slow takes longer either way
	always @(posedge clk_in) begin
		for (int i = 0; i < N; i++) begin
			if ($isunknown(en_in[i]) || en_in[i] === pgood_out[i] ||
				(en_in[i] && dead_in[i]) || (!en_in[i] && stuck_in[i])) begin
				cnt[i] <= 0;
			end else if (cnt[i] >= (slow_in[i] ? SLOW : FAST)) begin
				pgood_out[i] <= en_in[i];
				cnt[i] <= 0;
			end else begin
				cnt[i] <= cnt[i] + 1;
			end
		end
	end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench of the power converter sequencer
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import seq_pkg::*;
	// ==========================================================================
	// signals
	localparam int F_UP = 0;
	localparam int F_DOWN = 1;
	localparam int F_STABLE = 2;
	localparam int F_WARN = 3;
	localparam int F_FAULT = 4;
	logic clk = 1'b0;
	logic rst = 1'b1;
	bus_req_s bus_req = '0;
	logic [31:0] rdata;
	logic enable = 1'b0;
	logic [1:0] ctl = 2'b11;
	logic [1:0] pgood;
	logic [1:0] conv_en;
	logic [1:0] sts;
	logic up, down, stable, warn, fault;
	logic [4:0] flags;
	logic [1:0] slow = 2'b10;
	logic [1:0] dead = 2'b00;
	logic [1:0] stuck = 2'b00;
	int n_mismatch = 0;
	int check_count = 0;
	int bad_order = 0;
	int cyc = 0;
	assign flags = {fault, warn, stable, down, up};
	always #12.5 clk = ~clk;
	// ==========================================================================
	// design and converters
	power_converter_sequencer #(.N_CONV(2), .N_CTL(2), .N_STS(2), .TICK_CYCLES(4)) dut_u (
		.REF_CLK_IN(clk), .RESET_IN(rst), .BUS_REQ_IN(bus_req), .BUS_RDATA_OUT(rdata),
		.ENABLE_IN(enable), .CTL_IN(ctl), .PGOOD_IN(pgood), .CONV_EN_OUT(conv_en),
		.SYS_STABLE_OUT(stable), .SYS_UP_OUT(up), .SYS_DOWN_OUT(down), .WARN_OUT(warn),
		.FAULT_OUT(fault), .STS_OUT(sts)
	);
	conv_model #(.N(2)) conv_u (
		.clk_in(clk), .en_in(conv_en), .slow_in(slow), .dead_in(dead), .stuck_in(stuck),
		.pgood_out(pgood)
	);
	// ==========================================================================
	// helpers
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk) bus_req.wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe, so sample mid-cycle
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk) bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk) bus_req.rd <= 1'b0;
		@(negedge clk) check(name, rdata, exp);
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	// bounded wait; converter 1 on while converter 0 off is never legal
	task automatic wait_on(input int b, input int lim);
		cyc = 0;
		while (flags[b] !== 1'b1 && cyc < lim) begin
			@(negedge clk);
			cyc++;
			if (conv_en === 2'b10) bad_order++;
		end
	endtask
	// ==========================================================================
	// scenarios
	task automatic reset_regs();
		idle(2);
		check("sys_down", down, 1);
		check("conv_en", conv_en, 0);
		check("sts_empty", sts, 2'b11);
		rd_chk("ctrl", REG_CTRL, 32'h3);
		rd_chk("on_max", REG_ON_MAX, {16'h0, RST_ON_MAX});
		rd_chk("off_max", REG_OFF_MAX, {16'h0, RST_OFF_MAX});
		rd_chk("stable_t", REG_STABLE, {16'h0, RST_STABLE});
		rd_chk("status", REG_STATUS, 32'h2);
		bus_wr(8'h30, 32'hffffffff);
		rd_chk("unmapped", 8'h30, 32'h0);
	endtask
	task automatic power_up();
		bus_wr(REG_STABLE, 32'h2);
		@(posedge clk) enable <= 1'b1;
		wait_on(F_UP, 300);
		check("sys_up", up, 1);
		check("conv_en", conv_en, 2'b11);
		check("sys_down", down, 0);
		check("order_up", bad_order, 0);
		wait_on(F_STABLE, 400);
		check("stable", stable, 1);
		check("stable_len", cyc >= 125 && cyc <= 300, 1);
	endtask
	task automatic status_outs();
		bus_wr(REG_STS_BASE, 32'h3);
		bus_wr(REG_STS_BASE + 8'h04, 32'h3);
		bus_wr(REG_STS_BASE + 8'h08, 32'h1);
		bus_wr(REG_STS_BASE + 8'h0c, 32'h0);
		idle(2);
		check("sts_and", sts, 2'b01);
		bus_wr(REG_POL, 32'h200);
		idle(2);
		check("sts_pol", sts, 2'b11);
		rd_chk("sts_mask", REG_STS_BASE + 8'h08, 32'h1);
	endtask
	task automatic power_down_warn();
		@(posedge clk) stuck <= 2'b10;
		bus_wr(REG_OFF_MAX, 32'h2);
		@(posedge clk) enable <= 1'b0;
		wait_on(F_WARN, 200);
		check("warn", warn, 1);
		wait_on(F_DOWN, 300);
		check("sys_down", down, 1);
		check("conv_en", conv_en, 0);
		check("order_dn", bad_order, 0);
		check("stable_off", stable, 0);
		check("sts_follow", sts, 2'b00);
		rd_chk("warns", REG_WARNS, 32'h2);
		@(posedge clk) stuck <= 2'b00;
	endtask
	// gate holds power-up, force takes it down, then polarity flips the force input
	task automatic ctl_gate_force();
		bus_wr(REG_POL, 32'h0);
		bus_wr(REG_CTRL, 32'h103);
		@(posedge clk) ctl <= 2'b10;
		bus_wr(REG_CTRL, 32'h107);
		idle(20);
		check("gated", conv_en, 2'b00);
		@(posedge clk) ctl <= 2'b11;
		wait_on(F_UP, 300);
		check("ungated", up, 1);
		check("warn_clr", warn, 0);
		bus_wr(REG_CTRL, 32'h20103);
		@(posedge clk) ctl <= 2'b01;
		wait_on(F_DOWN, 300);
		check("forced", down, 1);
		bus_wr(REG_POL, 32'h2);
		bus_wr(REG_CTRL, 32'h20107);
		wait_on(F_UP, 300);
		check("ctl_low", up, 1);
	endtask
	task automatic fault_path();
		bus_wr(REG_CTRL, 32'h2010b);
		wait_on(F_DOWN, 300);
		check("cmd_off", down, 1);
		@(posedge clk) dead <= 2'b01;
		bus_wr(REG_ON_MAX, 32'h2);
		bus_wr(REG_CTRL, 32'h20107);
		wait_on(F_FAULT, 200);
		check("fault", fault, 1);
		idle(4);
		check("fault_en", conv_en, 2'b00);
		check("fault_up", up, 0);
		rd_chk("faults", REG_FAULTS, 32'h1);
	endtask
	// ==========================================================================
	// run control
	task final_report();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		reset_regs();
		power_up();
		status_outs();
		power_down_warn();
		ctl_gate_force();
		fault_path();
		final_report();
	end
	// the whole run needs well under a thousand cycles; this leaves ample margin
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		final_report();
	end
endmodule
`default_nettype wire
